// ---- core/diag_monitor_pkg.sv ----
`default_nettype none
package diag_monitor_pkg;
  // characters
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_DASH  = 8'h2d;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ALPHA = 8'h37;
  localparam logic [7:0] CH_L     = 8'h4c;
  localparam logic [7:0] CH_X     = 8'h58;
  localparam logic [7:0] CH_O     = 8'h4f;
  localparam logic [7:0] CH_U     = 8'h55;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_P     = 8'h50;
  localparam logic [7:0] CH_I     = 8'h49;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_C     = 8'h43;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_E     = 8'h45;
  // commands
  localparam logic [7:0] CMD_MENU  = CH_SPACE;
  localparam logic [7:0] CMD_AUDIO = CH_A;
  localparam logic [7:0] CMD_POL   = CH_P;
  localparam logic [7:0] CMD_RCNT  = CH_E;
  localparam logic [7:0] CMD_CLR   = CH_C;
  localparam logic [7:0] CMD_HW    = CH_S;
  localparam logic [7:0] CMD_IO    = CH_I;
  // line card error bits
  localparam int LC_JUST_RESET = 0;
  localparam int LC_PRES_CHG   = 1;
  localparam int LC_FIBER_CHG  = 2;
  localparam int LC_HW_FAULT   = 3;
  localparam int LC_MUX_1_4    = 4;
  localparam int LC_MUX_5_8    = 5;
  localparam int LC_MUX_9_12   = 6;
  localparam int LC_EN_CHG     = 7;
  // crosspoint card error bits (bit 3 unused)
  localparam int XP_PWR_TEMP   = 0;
  localparam int XP_COMM_ERR   = 1;
  localparam int XP_SEAT_ERR   = 2;
  localparam int XP_LEVEL_CHG  = 4;
  localparam int XP_OFFSET_CHG = 5;
  localparam int XP_SYSTYPE    = 6;
  localparam int XP_JUST_RESET = 7;
  // register byte offsets
  localparam logic [7:0] OFS_PRIMARY_ID = 8'h00;
  localparam logic [7:0] OFS_AUDIO_ID   = 8'h04;
  localparam logic [7:0] OFS_SYNC_SEL   = 8'h08;
  localparam logic [7:0] OFS_ALARM_IND  = 8'h0c;
  localparam logic [7:0] OFS_REF_ONE    = 8'h10;
  localparam logic [7:0] OFS_REF_TWO    = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h1c;
  localparam logic [7:0] OFS_TEST_POINT = 8'h20;
  localparam logic [7:0] OFS_XPT_PRES   = 8'h24;
  localparam logic [7:0] OFS_LINK_ERR   = 8'h28;
  localparam logic [7:0] OFS_CHANGE     = 8'h2c;
  localparam logic [7:0] OFS_CONTROL    = 8'h30;
  // reset values and reset counter ceiling
  localparam logic [7:0] LINK_NO_ALARM  = 8'hff;
  localparam logic [7:0] RST_MASK       = 8'h00;
  localparam logic [7:0] RST_TEST       = 8'h00;
  localparam logic [7:0] CNT_MAX        = 8'hff;
  // report lengths, last index
  localparam logic [3:0] LAST_LINE  = 4'd7;
  localparam logic [3:0] LAST_MENU  = 4'd3;
  localparam logic [3:0] LAST_POL   = 4'd5;
  localparam logic [3:0] LAST_AUDIO = 4'd8;
  typedef enum logic [2:0] {
    R_IDLE, R_EVT, R_MENU, R_POL, R_AUDIO, R_RCNT, R_IO
  } resp_e;
endpackage
`default_nettype wire

// ---- core/diag_status_reporter.sv ----
`default_nettype none
// How it works
// - serial diagnostic port acts as a data terminal end, 8N1 rx and tx
// - space sends the command list; otherwise strictly command then response
// - hidden A prints audio subrouter identity when that subrouter exists
// - hidden P flips alarm input polarity; hardware report shows it
// - per-card reset counts kept; hidden E prints each card's count
// - hidden C zeroes every per-card reset counter
// - every polled card returns an error byte; I command lists them
// - nonzero error byte sends an unsolicited event report once any report in progress ends
// - event first field: L for line card, X for crosspoint card
// - event second field: zero-based slot number in hexadecimal
// - event third field: error byte bitmap, conditions ORed together
// - line bits: 01 reset, 02 presence, 04 fiber, 08 hardware fault
// - line bits 10,20,40 mux select groups changed; 80 enable changed
// - crosspoint bits: 01 power/temp, 02 comms, 04 seating, 80 reset
// - crosspoint bits 10 level, 20 offset, 40 system type changed
// - link error code register holds current link code, FF no alarm
// - event change counter increments by one on each system event
// - reference sync status low three hex digits hold lines per frame
// - primary identity register carries device code in bits 15:8, revision in bits 7:0
module diag_status_reporter
  import diag_monitor_pkg::*;
#(
  parameter int         LINE_SLOTS = 96,
  parameter int         XPT_SLOTS  = 8,
  parameter int         BAUD_DIV   = 1736,
  parameter logic [7:0] DEV_ID     = 8'h3a, // arbitrary value
  parameter logic [7:0] DEV_REV    = 8'h01, // arbitrary value
  parameter logic [7:0] AUDIO_ID   = 8'h3b  // arbitrary value
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // diagnostic serial port
  input  wire logic        serial_rx,
  output logic             serial_tx,
  // card poll results
  input  wire logic        poll_valid,
  input  wire logic        poll_is_xpt,
  input  wire logic [6:0]  poll_slot,
  input  wire logic [7:0]  poll_err,
  output logic             poll_ready,
  // system status
  input  wire logic        alarm_input,
  input  wire logic        link_alarm,
  input  wire logic [7:0]  link_alarm_code,
  input  wire logic        audio_present,
  input  wire logic [7:0]  sync_select,
  input  wire logic [11:0] ref_one_lines,
  input  wire logic [11:0] ref_two_lines,
  input  wire logic [7:0]  xpt_present,
  output logic             alarm_active,
  output logic [7:0]       test_point
);
  localparam int ENTRIES = LINE_SLOTS + XPT_SLOTS;
  localparam logic [7:0]  LS8     = 8'(LINE_SLOTS);
  localparam logic [7:0]  LAST_EN = 8'(ENTRIES - 1);
  localparam logic [15:0] DIV_RLD = 16'(BAUD_DIV - 1);
  localparam logic [15:0] DIV_HLF = 16'(BAUD_DIV / 2);

  typedef struct packed {
    logic                      rx1;
    logic                      rx2;
    logic                      rx_busy;
    logic [15:0]               rx_div;
    logic [3:0]                rx_bit;
    logic [7:0]                rx_sh;
    logic                      tx_line;
    logic                      tx_busy;
    logic [15:0]               tx_div;
    logic [3:0]                tx_bit;
    logic [8:0]                tx_sh;
    resp_e                     mode;
    logic [3:0]                idx;
    logic [7:0]                ent;
    logic                      cmd_pend;
    resp_e                     cmd_mode;
    logic                      evt_pend;
    logic                      evt_x;
    logic [6:0]                evt_slot;
    logic [7:0]                evt_err;
    logic                      poll_rdy;
    logic [ENTRIES-1:0][7:0]   last_err;
    logic [ENTRIES-1:0][7:0]   rst_cnt;
    logic                      pol;
    logic                      al1;
    logic                      al2;
    logic                      alarm;
    logic                      fault;
    logic [7:0]                link_err;
    logic [7:0]                change;
    logic [7:0]                mask;
    logic [7:0]                test;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'ha) ? CH_ZERO + {4'h0, n} : CH_ALPHA + {4'h0, n};
  endfunction

  // one "T SS VV<cr>" line, shared by events and listings
  function automatic logic [7:0] line_char(input logic       x,
                                           input logic [6:0] slot,
                                           input logic [7:0] val,
                                           input logic [3:0] pos);
    case (pos)
      4'd0:    line_char = x ? CH_X : CH_L;
      4'd2:    line_char = hexc({1'b0, slot[6:4]});
      4'd3:    line_char = hexc(slot[3:0]);
      4'd5:    line_char = hexc(val[7:4]);
      4'd6:    line_char = hexc(val[3:0]);
      4'd7:    line_char = CH_CR;
      default: line_char = CH_SPACE;
    endcase
  endfunction

  logic       e_x;
  logic [6:0] e_slot;
  logic [7:0] ch;
  logic       last;
  logic       rx_got;
  logic [7:0] p_ent;
  logic [31:0] rd;
  logic       hit;
  logic       wr;
  logic [3:0] aud_n;

  always_comb begin
    s_d = s_q;
    rx_got = 1'b0;
    e_x = (s_q.ent >= LS8);
    e_slot = e_x ? 7'(s_q.ent - LS8) : s_q.ent[6:0];
    p_ent = poll_is_xpt ? LS8 + {1'b0, poll_slot} : {1'b0, poll_slot};
    aud_n = 4'h0;
    // synchroniser for async pins
    s_d.rx1 = serial_rx;
    s_d.rx2 = s_q.rx1;
    s_d.al1 = alarm_input;
    s_d.al2 = s_q.al1;
    s_d.alarm = s_q.al2 ^ s_q.pol;

    // receiver, 8N1, mid-bit sampling
    if (!s_q.rx_busy) begin
      if (!s_q.rx2) begin
        s_d.rx_busy = 1'b1;
        s_d.rx_div = DIV_HLF;
        s_d.rx_bit = 4'd0;
      end
    end else if (s_q.rx_div != 16'h0) begin
      s_d.rx_div = s_q.rx_div - 16'h1;
    end else begin
      s_d.rx_div = DIV_RLD;
      if (s_q.rx_bit == 4'd0) begin
        // a glitch shorter than half a bit is not a start
        if (s_q.rx2) s_d.rx_busy = 1'b0;
        else s_d.rx_bit = 4'd1;
      end else if (s_q.rx_bit <= 4'd8) begin
        s_d.rx_sh = {s_q.rx2, s_q.rx_sh[7:1]};
        s_d.rx_bit = s_q.rx_bit + 4'd1;
      end else begin
        s_d.rx_busy = 1'b0;
        rx_got = s_q.rx2; // framing error drops the byte
      end
    end

    // command decode, one byte, case-sensitive, no terminator
    if (rx_got) begin
      case (s_q.rx_sh)
        CMD_MENU: begin
          s_d.cmd_pend = 1'b1;
          s_d.cmd_mode = R_MENU;
        end
        CMD_AUDIO: begin
          s_d.cmd_pend = 1'b1;
          s_d.cmd_mode = R_AUDIO;
        end
        CMD_POL: begin
          s_d.pol = ~s_q.pol;
          s_d.cmd_pend = 1'b1;
          s_d.cmd_mode = R_POL;
        end
        CMD_HW: begin
          s_d.cmd_pend = 1'b1;
          s_d.cmd_mode = R_POL;
        end
        CMD_RCNT: begin
          s_d.cmd_pend = 1'b1;
          s_d.cmd_mode = R_RCNT;
        end
        CMD_IO: begin
          s_d.cmd_pend = 1'b1;
          s_d.cmd_mode = R_IO;
        end
        CMD_CLR: begin
          for (int i = 0; i < ENTRIES; i++) s_d.rst_cnt[i] = 8'h00;
        end
        default: ;
      endcase
    end

    // card poll; counting after the clear lets a same-cycle reset win
    if (poll_valid && s_q.poll_rdy && (p_ent < 8'(ENTRIES))) begin
      s_d.last_err[p_ent] = poll_err;
      if ((!poll_is_xpt && poll_err[LC_JUST_RESET]) ||
          (poll_is_xpt && poll_err[XP_JUST_RESET])) begin
        if (s_d.rst_cnt[p_ent] != CNT_MAX)
          s_d.rst_cnt[p_ent] = s_d.rst_cnt[p_ent] + 8'h01;
      end
      s_d.fault = poll_is_xpt ?
        (poll_err[XP_PWR_TEMP] | poll_err[XP_COMM_ERR] |
         poll_err[XP_SEAT_ERR]) : poll_err[LC_HW_FAULT];
      if (poll_err != 8'h00) begin
        s_d.evt_pend = 1'b1;
        s_d.evt_x = poll_is_xpt;
        s_d.evt_slot = poll_slot;
        s_d.evt_err = poll_err;
        s_d.change = s_q.change + 8'h01;
      end
    end

    // character source for the current report
    case (s_q.mode)
      R_EVT: begin
        ch = line_char(s_q.evt_x, s_q.evt_slot, s_q.evt_err, s_q.idx);
        last = (s_q.idx == LAST_LINE);
      end
      R_MENU: begin
        case (s_q.idx)
          4'd0:    ch = CMD_HW;
          4'd2:    ch = CMD_IO;
          4'd3:    ch = CH_CR;
          default: ch = CH_SPACE;
        endcase
        last = (s_q.idx == LAST_MENU);
      end
      R_POL: begin
        case (s_q.idx)
          4'd0:    ch = CH_P;
          4'd1:    ch = CH_O;
          4'd2:    ch = CH_L;
          4'd4:    ch = s_q.pol ? CH_C : CH_O;
          4'd5:    ch = CH_CR;
          default: ch = CH_SPACE;
        endcase
        last = (s_q.idx == LAST_POL);
      end
      R_AUDIO: begin
        case (s_q.idx)
          4'd4:    aud_n = AUDIO_ID[7:4];
          4'd5:    aud_n = AUDIO_ID[3:0];
          default: aud_n = 4'h0;
        endcase
        case (s_q.idx)
          4'd0:    ch = CH_A;
          4'd1:    ch = CH_U;
          4'd2:    ch = CH_D;
          4'd3:    ch = CH_SPACE;
          4'd8:    ch = CH_CR;
          default: ch = audio_present ? hexc(aud_n) : CH_DASH;
        endcase
        last = (s_q.idx == LAST_AUDIO);
      end
      R_RCNT: begin
        ch = line_char(e_x, e_slot, s_q.rst_cnt[s_q.ent], s_q.idx);
        last = (s_q.idx == LAST_LINE);
      end
      R_IO: begin
        ch = line_char(e_x, e_slot, s_q.last_err[s_q.ent], s_q.idx);
        last = (s_q.idx == LAST_LINE);
      end
      default: begin
        ch = CH_SPACE;
        last = 1'b0;
      end
    endcase

    // transmitter and report sequencing
    if (s_q.tx_busy) begin
      if (s_q.tx_div != 16'h0) begin
        s_d.tx_div = s_q.tx_div - 16'h1;
      end else if (s_q.tx_bit == 4'd9) begin
        s_d.tx_busy = 1'b0;
      end else begin
        s_d.tx_line = s_q.tx_sh[0];
        s_d.tx_sh = {1'b1, s_q.tx_sh[8:1]};
        s_d.tx_bit = s_q.tx_bit + 4'd1;
        s_d.tx_div = DIV_RLD;
      end
    end else if (s_q.mode != R_IDLE) begin
      s_d.tx_busy = 1'b1;
      s_d.tx_line = 1'b0;
      s_d.tx_sh = {1'b1, ch};
      s_d.tx_bit = 4'd0;
      s_d.tx_div = DIV_RLD;
      s_d.idx = s_q.idx + 4'd1;
      if (last) begin
        s_d.idx = 4'd0;
        if ((s_q.mode == R_RCNT || s_q.mode == R_IO) &&
            s_q.ent != LAST_EN) begin
          s_d.ent = s_q.ent + 8'h01;
        end else begin
          if (s_q.mode == R_EVT) s_d.evt_pend = s_d.evt_x != s_q.evt_x ||
            s_d.evt_slot != s_q.evt_slot || s_d.evt_err != s_q.evt_err ?
            s_d.evt_pend : 1'b0;
          s_d.mode = R_IDLE;
        end
      end
    end else if (s_q.evt_pend) begin
      // events jump the command queue; a listing runs to its end first
      s_d.mode = R_EVT;
      s_d.idx = 4'd0;
    end else if (s_q.cmd_pend) begin
      s_d.mode = s_q.cmd_mode;
      if (!(rx_got && s_q.rx_sh inside {CMD_MENU, CMD_AUDIO, CMD_POL,
                                        CMD_HW, CMD_RCNT, CMD_IO}))
        s_d.cmd_pend = 1'b0;
      s_d.idx = 4'd0;
      s_d.ent = 8'h00;
    end
    // a new poll only while no event waits
    s_d.poll_rdy = !s_d.evt_pend;

    s_d.link_err = link_alarm ? link_alarm_code : LINK_NO_ALARM;

    // apb register file
    hit = 1'b1;
    case (paddr)
      OFS_PRIMARY_ID: rd = {16'h0, DEV_ID, DEV_REV};
      OFS_AUDIO_ID:   rd = audio_present ? {16'h0, AUDIO_ID, 8'h00} : 32'h0;
      OFS_SYNC_SEL:   rd = {24'h0, sync_select};
      OFS_ALARM_IND:  rd = {30'h0, s_q.fault, s_q.alarm};
      OFS_REF_ONE:    rd = {20'h0, ref_one_lines};
      OFS_REF_TWO:    rd = {20'h0, ref_two_lines};
      OFS_IRQ_MASK:   rd = {24'h0, s_q.mask};
      OFS_IRQ_STAT:   rd = {24'h0, s_q.mask & {5'h0, s_q.poll_rdy,
                                               s_q.cmd_pend, s_q.evt_pend}};
      OFS_TEST_POINT: rd = {24'h0, s_q.test};
      OFS_XPT_PRES:   rd = {24'h0, xpt_present};
      OFS_LINK_ERR:   rd = {24'h0, s_q.link_err};
      OFS_CHANGE:     rd = {24'h0, s_q.change};
      OFS_CONTROL:    rd = {31'h0, s_q.pol};
      default: begin
        rd = 32'h0;
        hit = 1'b0;
      end
    endcase
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && !penable) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !hit;
      s_d.prdata = pwrite ? 32'h0 : rd;
    end
    wr = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
    if (wr) begin
      case (paddr)
        OFS_IRQ_MASK:   s_d.mask = pwdata[7:0];
        OFS_TEST_POINT: s_d.test = pwdata[7:0];
        OFS_CONTROL:    s_d.pol = pwdata[0];
        default: ;
      endcase
    end

    if (!rst_b) begin
      s_d = '0;
      s_d.rx1 = 1'b1;
      s_d.rx2 = 1'b1;
      s_d.tx_line = 1'b1;
      s_d.mode = R_IDLE;
      s_d.cmd_mode = R_IDLE;
      s_d.poll_rdy = 1'b1;
      s_d.link_err = LINK_NO_ALARM;
      s_d.mask = RST_MASK;
      s_d.test = RST_TEST;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign serial_tx = s_q.tx_line;
  assign poll_ready = s_q.poll_rdy;
  assign alarm_active = s_q.alarm;
  assign test_point = s_q.test;
endmodule
`default_nettype wire

// ---- verification/diag_status_reporter_properties.sv ----
`default_nettype none
module diag_status_reporter_checker
  import diag_monitor_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h3a
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial and polls
  input wire logic        serial_tx,
  input wire logic        poll_valid,
  input wire logic [7:0]  poll_err,
  input wire logic        poll_ready,
  // status
  input wire logic        link_alarm,
  input wire logic [7:0]  link_alarm_code,
  input wire logic [11:0] ref_one_lines,
  input wire logic        alarm_active,
  input wire logic [7:0]  test_point
);
  wire logic [7:0] wr_low;
  assign wr_low = pwdata[7:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence ev_taken;
    poll_valid && poll_ready && poll_err != 8'h00;
  endsequence
  reset_state_a: assert property (
    $rose(rst_b) |-> serial_tx && poll_ready && !alarm_active
      && test_point == RST_TEST) else $error("bad state after reset");
  tx_bit_len_a: assert property (
    $fell(serial_tx) |-> !serial_tx [*8]) else $error("short low bit");
  event_busy_a: assert property (
    ev_taken |=> !poll_ready [*8]) else $error("event not started");
  quiet_poll_a: assert property (
    poll_valid && poll_ready && poll_err == 8'h00 |=> poll_ready)
    else $error("zero error byte started a report");
  id_read_a: assert property (
    rd_setup(OFS_PRIMARY_ID) |=> pready && prdata[31:8] == {16'h0, DEV_ID})
    else $error("identity code wrong");
  link_read_a: assert property (
    rd_setup(OFS_LINK_ERR) ##0 $stable(link_alarm) |=> prdata ==
      {24'h0, $past(link_alarm) ? $past(link_alarm_code) : LINK_NO_ALARM})
    else $error("link error code wrong");
  ref_read_a: assert property (
    rd_setup(OFS_REF_ONE) |=> prdata[11:0] == $past(ref_one_lines))
    else $error("lines per frame wrong");
  unmapped_a: assert property (
    psel && !penable && !pwrite && paddr > OFS_CONTROL
      |=> pready && pslverr && prdata == 32'h0) else $error("no slave error");
  pready_pulse_a: assert property (
    pready |=> !pready) else $error("pready longer than one cycle");
  tp_write_a: assert property (
    psel && penable && pready && pwrite && paddr == OFS_TEST_POINT
      |=> test_point == $past(wr_low)) else $error("test point not written");
endmodule
bind diag_status_reporter diag_status_reporter_checker #(
  .DEV_ID(DEV_ID)
) props_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_tx(serial_tx),
  .poll_valid(poll_valid), .poll_err(poll_err), .poll_ready(poll_ready),
  .link_alarm(link_alarm), .link_alarm_code(link_alarm_code),
  .ref_one_lines(ref_one_lines), .alarm_active(alarm_active),
  .test_point(test_point)
);
`default_nettype wire

// ---- verification/operator_terminal.sv ----
`default_nettype none
module operator_terminal #(
  parameter int BAUD_DIV = 8
) (
  // clock
  input  wire logic  sys_clk,
  // serial lines
  input  wire logic  serial_tx,
  output logic       serial_rx,
  // characters as displayed
  output logic       shown_valid,
  output logic [7:0] shown_char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_sh;
  initial begin
    serial_rx   = 1'b1;
    shown_valid = 1'b0;
    shown_char  = 8'h00;
  end
  // 8n1, lsb first; line idles high between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx <= fr[i];
      repeat (BAUD_DIV) @(posedge sys_clk);
    end
  endtask
  task automatic show(input logic [7:0] c);
    shown_char  <= c;
    shown_valid <= 1'b1;
    @(posedge sys_clk);
    shown_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  always begin
    @(negedge serial_tx);
    repeat (BAUD_DIV / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_DIV) @(posedge sys_clk);
      rx_sh[i] = serial_tx;
    end
    repeat (BAUD_DIV) @(posedge sys_clk);
    show(rx_sh);
    // reports carry no line feed, so the terminal adds one
    if (rx_sh == 8'h0d) show(8'h0a);
  end
endmodule
`default_nettype wire

// ---- verification/diag_status_reporter_bench.sv ----
`default_nettype none
module diag_status_reporter_bench
  import diag_monitor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         BD = 8;
  localparam logic [7:0] ID = 8'h5a; // arbitrary value
  localparam logic [7:0] RV = 8'h02; // arbitrary value
  localparam logic [7:0] AU = 8'h6c; // arbitrary value
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, poll_err, link_alarm_code, sync_select, xpt_present;
  logic [31:0] pwdata, prdata;
  logic        serial_rx, serial_tx, poll_valid, poll_is_xpt, poll_ready;
  logic [6:0]  poll_slot;
  logic        alarm_input, link_alarm, audio_present, alarm_active;
  logic [11:0] ref_one_lines, ref_two_lines;
  logic [7:0]  test_point, shown_char;
  logic        shown_valid;
  logic [32:0] ap_q[$];
  logic [7:0]  ch_q[$];
  logic [7:0]  rc[6], le[6];
  int          bad_count, cmp_count, seed, cyc;
  diag_status_reporter #(
    .LINE_SLOTS(4), .XPT_SLOTS(2), .BAUD_DIV(BD),
    .DEV_ID(ID), .DEV_REV(RV), .AUDIO_ID(AU)
  ) diag_status_reporter_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_rx(serial_rx),
    .serial_tx(serial_tx), .poll_valid(poll_valid),
    .poll_is_xpt(poll_is_xpt), .poll_slot(poll_slot), .poll_err(poll_err),
    .poll_ready(poll_ready), .alarm_input(alarm_input),
    .link_alarm(link_alarm), .link_alarm_code(link_alarm_code),
    .audio_present(audio_present), .sync_select(sync_select),
    .ref_one_lines(ref_one_lines), .ref_two_lines(ref_two_lines),
    .xpt_present(xpt_present), .alarm_active(alarm_active),
    .test_point(test_point)
  );
  operator_terminal #(.BAUD_DIV(BD)) operator_terminal_i (
    .sys_clk(sys_clk), .serial_tx(serial_tx), .serial_rx(serial_rx),
    .shown_valid(shown_valid), .shown_char(shown_char)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    // notes that never got their result are misses too
    bad_count += ch_q.size() + ap_q.size();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp_word(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_char(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // an output with no note behind it is compared against x and fails
  always @(posedge sys_clk) begin
    cyc++;
    if (psel && penable && pready && !pwrite)
      cmp_word({pslverr, prdata}, ap_q.size() ? ap_q.pop_front() : 33'hx);
    if (shown_valid === 1'b1)
      cmp_char(shown_char, ch_q.size() ? ch_q.pop_front() : 8'hxx);
    if (cyc == 90000) begin
      bad_count++;
      summarize();
    end
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'd10) ? CH_ZERO + {4'h0, n} : CH_ALPHA + {4'h0, n};
  endfunction
  task automatic note_s(input string s);
    for (int i = 0; i < s.len(); i++) begin
      ch_q.push_back(s[i]);
      if (s[i] == CH_CR) ch_q.push_back(8'h0a);
    end
  endtask
  task automatic note_line(input logic [7:0] t, a, v);
    note_s($sformatf("%c %c%c %c%c\015", t, hx(a[7:4]), hx(a[3:0]),
                     hx(v[7:4]), hx(v[3:0])));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    ap_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic poll(input logic x, input logic [6:0] s, input logic [7:0] e);
    poll_valid  <= 1'b1;
    poll_is_xpt <= x;
    poll_slot   <= s;
    poll_err    <= e;
    do begin
      @(posedge sys_clk);
    end while (poll_ready !== 1'b1);
    poll_valid <= 1'b0;
    if (e != 8'h00) note_line(x ? CH_X : CH_L, {1'b0, s}, e);
    le[x ? s + 4 : s] = e;
    if (x ? e[XP_JUST_RESET] : e[LC_JUST_RESET]) rc[x ? s + 4 : s]++;
    @(posedge sys_clk);
  endtask
  task automatic drain();
    while (ch_q.size() != 0) begin
      @(posedge sys_clk);
    end
    repeat (40) @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    operator_terminal_i.send(c);
    drain();
  endtask
  task automatic note_list(input logic cnt);
    for (int k = 0; k < 6; k++)
      note_line(k < 4 ? CH_L : CH_X, k % 4, cnt ? rc[k] : le[k]);
  endtask
  initial begin
    logic [31:0] r;
    {psel, penable, pwrite, poll_valid, poll_is_xpt, link_alarm} = 6'h0;
    {alarm_input, audio_present, paddr, pwdata, poll_slot, poll_err} = 'h0;
    seed = 85711;
    r = $random(seed);
    {link_alarm_code, sync_select, xpt_present} = r[23:0];
    {ref_one_lines, ref_two_lines} = {r[31:20], r[11:0]};
    for (int k = 0; k < 6; k++) {rc[k], le[k]} = 16'h0;
    rst_b = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(OFS_PRIMARY_ID, {17'h0, ID, RV});
    rd(OFS_CHANGE, 33'h0);
    apb(1'b1, OFS_LINK_ERR, 32'h0);
    rd(OFS_LINK_ERR, {25'h0, LINK_NO_ALARM});
    rd(8'h3c, {1'b1, 32'h0});
    apb(1'b1, OFS_TEST_POINT, r);
    rd(OFS_TEST_POINT, {25'h0, r[7:0]});
    link_alarm <= 1'b1;
    // the code register lags the pin by one clock
    @(posedge sys_clk);
    rd(OFS_LINK_ERR, {25'h0, link_alarm_code});
    link_alarm <= 1'b0;
    rd(OFS_REF_ONE, {21'h0, ref_one_lines});
    for (int k = 0; k < 6; k++) poll(k > 3, k % 4, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      poll(1'b0, {5'h0, r[1:0]}, 8'h01 << i);
      poll(1'b1, {6'h0, r[2]}, 8'h01 << i);
    end
    poll(1'b1, 7'd1, 8'ha0);
    drain();
    rd(OFS_CHANGE, 33'h11);
    note_s("S I\015");
    cmd(CMD_MENU);
    cmd(8'h73);
    note_s("POL O\015");
    cmd(CMD_HW);
    note_s("POL C\015");
    cmd(CMD_POL);
    rd(OFS_ALARM_IND, 33'h1);
    cmp_char({7'h0, alarm_active}, 8'h01);
    audio_present <= 1'b1;
    note_s($sformatf("AUD %c%c00\015", hx(AU[7:4]), hx(AU[3:0])));
    cmd(CMD_AUDIO);
    audio_present <= 1'b0;
    note_s("AUD ----\015");
    cmd(CMD_AUDIO);
    note_list(1'b1);
    cmd(CMD_RCNT);
    note_list(1'b0);
    cmd(CMD_IO);
    cmd(CMD_CLR);
    for (int k = 0; k < 6; k++) rc[k] = 8'h00;
    note_list(1'b1);
    cmd(CMD_RCNT);
    summarize();
  end
endmodule
`default_nettype wire
